// ### logic/tlbf_pkg.sv
package tlbf_pkg;

  // ---------------------------------------------------------------------------
  // Exception codes, vector offset and status bit positions
  // ---------------------------------------------------------------------------
  localparam logic [11:0] TLBF_EXC_PROT_RD  = 12'h0a0;
  localparam logic [11:0] TLBF_EXC_PROT_WR  = 12'h0c0;
  localparam logic [11:0] TLBF_EXC_FIRST_WR = 12'h080;
  localparam logic [31:0] TLBF_VEC_OFS      = 32'h0000_0100;
  localparam int          TLBF_SR_PRIV_POS  = 30;
  localparam int          TLBF_SR_BANK_POS  = 29;
  localparam int          TLBF_SR_BLOCK_POS = 28;
  localparam logic [31:0] TLBF_SR_RESET     = 32'h7000_00f0;

  // ---------------------------------------------------------------------------
  // Mapped array windows
  // ---------------------------------------------------------------------------
  localparam logic [31:0] TLBF_TAG_WIN_OFS  = 32'hf200_0000;
  localparam logic [31:0] TLBF_D1_WIN_OFS   = 32'hf300_0000;
  localparam logic [31:0] TLBF_D2_WIN_OFS   = 32'hf380_0000;
  localparam logic [7:0]  TLBF_TAG_SEL      = TLBF_TAG_WIN_OFS[31:24];
  localparam logic [8:0]  TLBF_D1_SEL       = TLBF_D1_WIN_OFS[31:23];
  localparam logic [8:0]  TLBF_D2_SEL       = TLBF_D2_WIN_OFS[31:23];
  localparam int          TLBF_ENT_LSB      = 8;
  localparam int          TLBF_ENT_MSB      = 9;
  localparam logic [1:0]  TLBF_SIZE_WORD    = 2'h2;

  // ---------------------------------------------------------------------------
  // Field layout of the mapped words
  // ---------------------------------------------------------------------------
  localparam int TLBF_VPN_LSB   = 10;
  localparam int TLBF_VALID_POS = 8;
  localparam int TLBF_PPN_MSB   = 28;
  localparam int TLBF_SZ_HI_POS = 7;
  localparam int TLBF_PR_POS    = 6;
  localparam int TLBF_SZ_LO_POS = 4;
  localparam int TLBF_C_POS     = 3;
  localparam int TLBF_SH_POS    = 1;
  localparam int TLBF_TC_POS    = 3;
  localparam int TLBF_TAG_W     = 30;
  localparam int TLBF_D1_W      = 24;
  localparam int TLBF_D2_W      = 4;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] vaddr;
    logic        write;
    logic        hit;
    logic [1:0]  prot;
    logic        dirty;
    logic [7:0]  address_space_id;
    logic [31:0] pc;
    logic        delay_slot;
    logic [31:0] branch_pc;
    logic [31:0] status;
    logic [31:0] gen15;
    logic [31:0] vector_base_reg;
  } tlbf_fault_req_s;

  typedef struct packed {
    logic        take;
    logic [31:0] target;
    logic [11:0] event_code;
    logic [31:0] page_high;
    logic [31:0] fault_addr;
    logic [31:0] saved_pc;
    logic [31:0] saved_status;
    logic [31:0] saved_general;
    logic [31:0] status;
  } tlbf_fault_rec_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic        ifetch;
  } tlbf_mm_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } tlbf_mm_rsp_s;

  typedef enum logic [1:0] {TLBF_ARR_NONE, TLBF_ARR_TAG, TLBF_ARR_D1, TLBF_ARR_D2} tlbf_arr_e;

endpackage

// ### logic/tlbf_mem.sv
`timescale 1ns/100ps
module tlbf_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     ref_clk,
  input  wire logic                     clk_en,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [W-1:0]             wdata,
  output logic      [W-1:0]             rdata_r
);

  logic [W-1:0] mem [DEPTH];

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("tlbf_mem needs DEPTH of two or more and a positive width");
  end

  // The array holds no reset: software loads every entry before use.
  always_ff @(posedge ref_clk) begin
    if (clk_en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      rdata_r <= mem[addr];
    end
  end

endmodule

// ### logic/tlbf_fault_mmap.sv
`timescale 1ns/100ps
// What this block does
// - Flag access violation when hit but protection forbids.
// - Violation code is read or write code.
// - Record faulting page and full address.
// - Save faulting pc, or delayed branch address.
// - Save status and general fifteen on entry.
// - Set privilege, block and bank bits.
// - Branch to vector base plus 100 hex.
// - Flag first write on permitted write, clean page.
// - First write uses code 080 hex.
// - Only word data accesses; no fetches; reserved zero.
// - Top byte F2 selects tag array, entry bits.
// - Tag word holds page, valid and space id.
// - Top nine bits select first data array.
// - First data word holds page, flags and size.
// - Top nine bits select second data array.
// - Second data word holds attribute and timing.
// - One valid bit shared by tag and first data.
module tlbf_fault_mmap #(
  parameter int ENTRIES = 4
) (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  input  wire tlbf_pkg::tlbf_fault_req_s fault_req,
  output tlbf_pkg::tlbf_fault_rec_s      fault_rec_r,
  input  wire tlbf_pkg::tlbf_mm_req_s    mm_req,
  output tlbf_pkg::tlbf_mm_rsp_s         mm_rsp_r
);
  import tlbf_pkg::*;

  localparam int EW = $clog2(ENTRIES);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The entry field is two address bits wide, so only four entries are served.
  if (ENTRIES != 4) begin : g_chk
    $error("tlbf_fault_mmap serves exactly four entries");
  end

  // ---------------------------------------------------------------------------
  // Fault detection
  // ---------------------------------------------------------------------------
  logic        allowed;
  logic        prot_fault;
  logic        first_wr_fault;
  logic        any_fault;
  logic [11:0] code_nxt;
  logic [31:0] status_nxt;

  always_comb begin
    // The privileged mode may always read; bit one of the field opens the page
    // to the user mode and bit zero opens it to writes.
    if (fault_req.status[TLBF_SR_PRIV_POS]) begin
      allowed = !fault_req.write || fault_req.prot[0];
    end else begin
      allowed = fault_req.prot[1] && (!fault_req.write || fault_req.prot[0]);
    end
  end

  // The core folds the purge and write-back ops into reads and the invalidate
  // and allocate-store ops into writes before it raises a request.
  assign prot_fault     = fault_req.valid && fault_req.hit && !allowed;
  assign first_wr_fault = fault_req.valid && fault_req.hit && allowed &&
                          fault_req.write && !fault_req.dirty;
  assign any_fault      = prot_fault || first_wr_fault;

  always_comb begin
    if (prot_fault) begin
      code_nxt = fault_req.write ? TLBF_EXC_PROT_WR : TLBF_EXC_PROT_RD;
    end else begin
      code_nxt = TLBF_EXC_FIRST_WR;
    end
  end

  always_comb begin
    status_nxt                    = fault_req.status;
    status_nxt[TLBF_SR_PRIV_POS]  = 1'b1;
    status_nxt[TLBF_SR_BANK_POS]  = 1'b1;
    status_nxt[TLBF_SR_BLOCK_POS] = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Fault record
  // ---------------------------------------------------------------------------
  // The record is loaded only on a fault, so the handler still finds it after
  // the core has moved on; take itself is a one-cycle strobe.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fault_rec_r.take          <= 1'b0;
      fault_rec_r.target        <= '0;
      fault_rec_r.event_code    <= '0;
      fault_rec_r.page_high     <= '0;
      fault_rec_r.fault_addr    <= '0;
      fault_rec_r.saved_pc      <= '0;
      fault_rec_r.saved_status  <= '0;
      fault_rec_r.saved_general <= '0;
      fault_rec_r.status        <= TLBF_SR_RESET;
    end else if (clk_en) begin
      fault_rec_r.take <= any_fault;
      if (any_fault) begin
        fault_rec_r.target        <= 32'(fault_req.vector_base_reg + TLBF_VEC_OFS);
        fault_rec_r.event_code    <= code_nxt;
        fault_rec_r.page_high     <= {fault_req.vaddr[31:TLBF_VPN_LSB], 2'h0, fault_req.address_space_id};
        fault_rec_r.fault_addr    <= fault_req.vaddr;
        fault_rec_r.saved_pc      <= fault_req.delay_slot ? fault_req.branch_pc : fault_req.pc;
        fault_rec_r.saved_status  <= fault_req.status;
        fault_rec_r.saved_general <= fault_req.gen15;
        fault_rec_r.status        <= status_nxt;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Fault record checks
  // ---------------------------------------------------------------------------
  property p_fault_take;
    @(posedge ref_clk) disable iff (!resetn) (clk_en && any_fault) |=> fault_rec_r.take;
  endproperty
  a_fault_take: assert property (p_fault_take) else $error("fault not reported");

  property p_prot_code;
    @(posedge ref_clk) disable iff (!resetn) (clk_en && prot_fault) |=>
      fault_rec_r.event_code == ($past(fault_req.write) ? TLBF_EXC_PROT_WR : TLBF_EXC_PROT_RD);
  endproperty
  a_prot_code: assert property (p_prot_code) else $error("access violation with wrong code");

  property p_first_code;
    @(posedge ref_clk) disable iff (!resetn) (clk_en && first_wr_fault) |=>
      fault_rec_r.event_code == TLBF_EXC_FIRST_WR;
  endproperty
  a_first_code: assert property (p_first_code) else $error("first write fault with wrong code");

  property p_vector;
    @(posedge ref_clk) disable iff (!resetn) (clk_en && any_fault) |=>
      fault_rec_r.target == 32'($past(fault_req.vector_base_reg) + TLBF_VEC_OFS);
  endproperty
  a_vector: assert property (p_vector) else $error("fault vector is wrong");

  property p_saved_pc;
    @(posedge ref_clk) disable iff (!resetn) (clk_en && any_fault) |=>
      fault_rec_r.saved_pc == ($past(fault_req.delay_slot) ? $past(fault_req.branch_pc) : $past(fault_req.pc));
  endproperty
  a_saved_pc: assert property (p_saved_pc) else $error("saved pc is wrong");

  property p_status_bits;
    @(posedge ref_clk) disable iff (!resetn) fault_rec_r.take |->
      fault_rec_r.status[TLBF_SR_PRIV_POS] && fault_rec_r.status[TLBF_SR_BANK_POS] &&
      fault_rec_r.status[TLBF_SR_BLOCK_POS];
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bits not set on fault");

  // ---------------------------------------------------------------------------
  // Mapped array decode
  // ---------------------------------------------------------------------------
  tlbf_arr_e     arr_sel;
  logic          req_bad;
  logic [EW-1:0] ent_sel;

  always_comb begin
    arr_sel = TLBF_ARR_NONE;
    if (mm_req.addr[31:24] == TLBF_TAG_SEL) begin
      arr_sel = TLBF_ARR_TAG;
    end else if (mm_req.addr[31:23] == TLBF_D1_SEL) begin
      arr_sel = TLBF_ARR_D1;
    end else if (mm_req.addr[31:23] == TLBF_D2_SEL) begin
      arr_sel = TLBF_ARR_D2;
    end
  end

  // Only the entry field picks the entry, so one entry aliases across its window.
  assign ent_sel = mm_req.addr[TLBF_ENT_MSB:TLBF_ENT_LSB];

  // A refused access is still answered, with the error flag, and touches no array.
  assign req_bad = (arr_sel == TLBF_ARR_NONE) || mm_req.ifetch || (mm_req.size != TLBF_SIZE_WORD) ||
                   (mm_req.addr[1:0] != 2'h0);

  // ---------------------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------------------
  typedef enum {MM_IDLE, MM_ACCESS, MM_RESPOND, MM_HOLD} tlbf_mm_st_e;

  tlbf_mm_st_e   st_r;
  tlbf_mm_st_e   st_nxt;
  tlbf_arr_e     arr_r;
  logic [EW-1:0] ent_r;
  logic          we_r;
  logic          bad_r;
  logic [31:0]   wdata_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      MM_IDLE: begin
        if (mm_req.req) begin
          st_nxt = MM_ACCESS;
        end
      end
      MM_ACCESS: begin
        st_nxt = MM_RESPOND;
      end
      MM_RESPOND: begin
        st_nxt = MM_HOLD;
      end
      MM_HOLD: begin
        if (!mm_req.req) begin
          st_nxt = MM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= MM_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      arr_r   <= TLBF_ARR_NONE;
      ent_r   <= '0;
      we_r    <= 1'b0;
      bad_r   <= 1'b0;
      wdata_r <= '0;
    end else if (clk_en && st_r == MM_IDLE && mm_req.req) begin
      arr_r   <= arr_sel;
      ent_r   <= ent_sel;
      we_r    <= mm_req.we;
      bad_r   <= req_bad;
      wdata_r <= mm_req.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Array storage
  // ---------------------------------------------------------------------------
  logic                  wr_go;
  logic                  tag_we;
  logic                  d1_we;
  logic                  d2_we;
  logic [TLBF_TAG_W-1:0] tag_wd;
  logic [TLBF_D1_W-1:0]  d1_wd;
  logic [TLBF_D2_W-1:0]  d2_wd;
  logic [TLBF_TAG_W-1:0] tag_rd;
  logic [TLBF_D1_W-1:0]  d1_rd;
  logic [TLBF_D2_W-1:0]  d2_rd;
  logic                  valid_r [ENTRIES];

  assign wr_go  = (st_r == MM_ACCESS) && we_r && !bad_r;
  assign tag_we = wr_go && (arr_r == TLBF_ARR_TAG);
  assign d1_we  = wr_go && (arr_r == TLBF_ARR_D1);
  assign d2_we  = wr_go && (arr_r == TLBF_ARR_D2);

  // Reserved bits are dropped here, so whatever software put there is lost.
  assign tag_wd = {wdata_r[31:TLBF_VPN_LSB], wdata_r[7:0]};
  assign d1_wd  = {wdata_r[TLBF_PPN_MSB:TLBF_VPN_LSB], wdata_r[TLBF_SZ_HI_POS], wdata_r[TLBF_PR_POS],
                   wdata_r[TLBF_SZ_LO_POS], wdata_r[TLBF_C_POS], wdata_r[TLBF_SH_POS]};
  assign d2_wd  = wdata_r[TLBF_D2_W-1:0];

  tlbf_mem #(.W(TLBF_TAG_W), .DEPTH(ENTRIES)) i_tag_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .we      (tag_we),
    .addr    (ent_r),
    .wdata   (tag_wd),
    .rdata_r (tag_rd)
  );

  tlbf_mem #(.W(TLBF_D1_W), .DEPTH(ENTRIES)) i_d1_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .we      (d1_we),
    .addr    (ent_r),
    .wdata   (d1_wd),
    .rdata_r (d1_rd)
  );

  tlbf_mem #(.W(TLBF_D2_W), .DEPTH(ENTRIES)) i_d2_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .we      (d2_we),
    .addr    (ent_r),
    .wdata   (d2_wd),
    .rdata_r (d2_rd)
  );

  // Two windows reach the valid flag, so it sits in flops beside the arrays.
  for (genvar g = 0; g < ENTRIES; g++) begin : g_valid
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        valid_r[g] <= 1'b0;
      end else if (clk_en && (tag_we || d1_we) && ent_r == EW'(g)) begin
        valid_r[g] <= wdata_r[TLBF_VALID_POS];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------------------
  logic [31:0] rdata_fmt;

  always_comb begin
    rdata_fmt = '0;
    unique case (arr_r)
      TLBF_ARR_TAG: begin
        rdata_fmt[31:TLBF_VPN_LSB] = tag_rd[TLBF_TAG_W-1:8];
        rdata_fmt[TLBF_VALID_POS]  = valid_r[ent_r];
        rdata_fmt[7:0]             = tag_rd[7:0];
      end
      TLBF_ARR_D1: begin
        rdata_fmt[TLBF_PPN_MSB:TLBF_VPN_LSB] = d1_rd[TLBF_D1_W-1:5];
        rdata_fmt[TLBF_VALID_POS]            = valid_r[ent_r];
        rdata_fmt[TLBF_SZ_HI_POS]            = d1_rd[4];
        rdata_fmt[TLBF_PR_POS]               = d1_rd[3];
        rdata_fmt[TLBF_SZ_LO_POS]            = d1_rd[2];
        rdata_fmt[TLBF_C_POS]                = d1_rd[1];
        rdata_fmt[TLBF_SH_POS]               = d1_rd[0];
      end
      TLBF_ARR_D2: begin
        rdata_fmt[TLBF_D2_W-1:0] = d2_rd;
      end
      TLBF_ARR_NONE: rdata_fmt = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mm_rsp_r <= '0;
    end else if (clk_en) begin
      if (st_r == MM_RESPOND) begin
        mm_rsp_r.ack   <= 1'b1;
        mm_rsp_r.err   <= bad_r;
        mm_rsp_r.rdata <= (bad_r || we_r) ? 32'h0 : rdata_fmt;
      end else if (st_r == MM_HOLD && !mm_req.req) begin
        mm_rsp_r.ack   <= 1'b0;
        mm_rsp_r.err   <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Access checks
  // ---------------------------------------------------------------------------
  sequence s_mm_start;
    clk_en && st_r == MM_IDLE && mm_req.req;
  endsequence
  sequence s_mm_answer;
    ##3 mm_rsp_r.ack;
  endsequence

  property p_mm_answer;
    @(posedge ref_clk) disable iff (!resetn) s_mm_start |-> s_mm_answer;
  endproperty
  a_mm_answer: assert property (p_mm_answer) else $error("mapped access not answered in time");

  property p_mm_refuse;
    @(posedge ref_clk) disable iff (!resetn) s_mm_start ##0 req_bad |-> ##3 (mm_rsp_r.ack && mm_rsp_r.err);
  endproperty
  a_mm_refuse: assert property (p_mm_refuse) else $error("bad mapped access not refused");
endmodule

// ### tb/tlbf_core_model.sv
`timescale 1ns/100ps
module tlbf_core_model (
  input  wire logic                   ref_clk,
  input  wire tlbf_pkg::tlbf_mm_rsp_s mm_rsp_r,
  output tlbf_pkg::tlbf_mm_req_s      mm_req
);
  import tlbf_pkg::*;
  initial mm_req = '0;
  task automatic mm(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int n = 0;
    repeat (8) @(posedge ref_clk);
    mm_req <= '{1'b1, w, a, d, TLBF_SIZE_WORD, 1'b0};
    do @(posedge ref_clk); while (mm_rsp_r.ack !== 1'b1 && ++n < 40);
    q = (mm_rsp_r.ack === 1'b1) ? mm_rsp_r.rdata : 'x;
    mm_req <= '{1'b0, 1'b0, ~a, ~d, 2'h0, 1'b0};
  endtask
endmodule

// ### tb/tlbf_fault_mmap_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t mismatch", $time); end end
module tlbf_fault_mmap_tb;
  import tlbf_pkg::*;
  localparam logic [31:0] WIN [3] = '{TLBF_TAG_WIN_OFS, TLBF_D1_WIN_OFS, TLBF_D2_WIN_OFS};
  localparam logic [31:0] MSK [3] = '{32'hffff_fdff, 32'h1fff_fdda, 32'h0000_000f};
  logic            ref_clk = 1'b0, resetn = 1'b0;
  tlbf_fault_req_s fq = '0;
  tlbf_fault_rec_s fr;
  tlbf_mm_req_s    mq;
  tlbf_mm_rsp_s    mr;
  logic [31:0]     q, v [4][3];
  int              n_mismatch = 0, total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  tlbf_fault_mmap i_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .fault_req(fq), .fault_rec_r(fr),
    .mm_req(mq), .mm_rsp_r(mr));
  tlbf_core_model i_core (.ref_clk(ref_clk), .mm_rsp_r(mr), .mm_req(mq));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic flt(input logic w, dy, input logic [1:0] p, input logic [11:0] ec);
    tlbf_fault_req_s r;
    r = 207'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
    {r.valid, r.hit, r.write, r.prot, r.dirty, r.status[30:28]} = {2'b11, w, p, dy, 3'h0};
    @(posedge ref_clk) fq <= r;
    @(posedge ref_clk) fq.valid <= 1'b0;
    repeat (8) if (fr.take !== 1'b1) @(negedge ref_clk);
    `CHK(fr.take, ec != 12'h0)
    if (ec != 12'h0) begin
      `CHK({fr.event_code, fr.target}, {ec, r.vector_base_reg + TLBF_VEC_OFS})
      `CHK({fr.page_high[31:10], fr.fault_addr}, {r.vaddr[31:10], r.vaddr})
      `CHK(fr.saved_pc, r.delay_slot ? r.branch_pc : r.pc)
      `CHK({fr.saved_status, fr.saved_general, fr.status}, {r.status, r.gen15, r.status | 32'h7000_0000})
    end
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h6e73));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      if (i < 12) v[i % 4][i / 4] = $urandom & MSK[i / 4];
      i_core.mm(i < 12, WIN[i / 4 % 3] | (i % 4 << 8) | ($urandom & 32'h007f_fcfc), v[i % 4][i / 4 % 3], q);
      if (i / 4 == 1) v[i % 4][0][8] = v[i % 4][1][8];
      if (i >= 12) `CHK(q & MSK[i / 4 % 3], v[i % 4][i / 4 % 3])
    end
    i_core.mm(1'b1, TLBF_TAG_WIN_OFS | 32'h1, ~v[0][0], q);
    `CHK(mr.err, 1'b1)
    i_core.mm(1'b0, 32'hf400_0000, 32'h0, q);
    `CHK({mr.err, q}, {1'b1, 32'h0})
    i_core.mm(1'b0, TLBF_TAG_WIN_OFS, 32'h0, q);
    `CHK(q & MSK[0], v[0][0])
    $display("mmap test done");
    repeat (2) begin
      flt(1'b1, 1'b1, 2'b00, TLBF_EXC_PROT_WR);
      flt(1'b0, 1'b0, 2'b00, TLBF_EXC_PROT_RD);
      flt(1'b1, 1'b0, 2'b11, TLBF_EXC_FIRST_WR);
      flt(1'b1, 1'b1, 2'b11, 12'h000);
    end
    $display("fault test done");
    wrap_up();
  end
endmodule
